//--- rtl/crc32_calc_unit.v
// How it works
// - divide mod 2 by writable coefficient
// - restart copies seed into checksum
// - restart bit write-only, self clearing
// - each calculation takes four clock cycles
// - data write feeds, data read returns result
// - first input uses seed, then accumulates
// - two-bit field selects input reversal
// - mirror bits inside 8/16/32 groups
// - optional whole-word mirror of result
// - no final xor on result
// - two-bit field selects generator width
// - scratch byte survives a restart
// - data byte/half/word, others word only
`timescale 1ns/1ps
`default_nettype none
`include "crc32_calc_unit_defs.vh"

module crc32_calc_unit (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    input  wire [3:0]  pstrb,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr
);

    // software visible state
    reg [31:0] checksum_value;      // running remainder
    reg [7:0]  scratch_byte;        // general purpose byte
    reg        output_bit_flip;     // mirror result on read
    reg [1:0]  input_bit_flip_sel;  // input reversal mode
    reg [1:0]  generator_width_sel; // generator width
    reg [31:0] seed_value;          // restart value
    reg [31:0] generator_coeff;     // generator coefficient

    // calculation engine state
    reg        busy;                // calculation running
    reg [2:0]  calc_cnt;            // cycle within calculation
    reg [2:0]  feed_bytes;          // bytes still meaningful
    reg [31:0] shift_in;            // input, left aligned

    // decode results of the current access
    reg        next_err;            // access refused
    reg [31:0] next_rdata;          // read value
    reg [31:0] lane_value;          // write data, right aligned
    reg [1:0]  lane_size;           // byte, half or word
    reg        lane_ok;             // legal strobe pattern
    reg [31:0] flipped_in;          // input after reversal
    reg [31:0] result_view;         // result as software sees it
    reg [2:0]  next_feed;           // byte count of the input
    reg [31:0] next_shift;          // left aligned input

    wire [31:0] step_out;           // remainder after one byte
    wire        access;             // access phase awaiting answer
    wire        wr_word;            // full word strobes

    assign access  = psel & penable & ~pready;
    assign wr_word = (pstrb == 4'hf);

    // mirror the bits inside each byte
    function [31:0] flip_bytes;
        input [31:0] v;
        integer k;
        begin
            for (k = 0; k < 32; k = k + 1) begin
                flip_bytes[k] = v[(k & 24) + 7 - (k & 7)];
            end
        end
    endfunction

    // mirror the bits inside each half word
    function [31:0] flip_halves;
        input [31:0] v;
        integer k;
        begin
            for (k = 0; k < 32; k = k + 1) begin
                flip_halves[k] = v[(k & 16) + 15 - (k & 15)];
            end
        end
    endfunction

    // mirror all 32 bits
    function [31:0] flip_word;
        input [31:0] v;
        integer k;
        begin
            for (k = 0; k < 32; k = k + 1) begin
                flip_word[k] = v[31 - k];
            end
        end
    endfunction

    // live remainder bits for a generator width
    function [31:0] width_mask;
        input [1:0] sel;
        begin
            case (sel)
                `WSEL_16: width_mask = 32'h0000_ffff;
                `WSEL_8:  width_mask = 32'h0000_00ff;
                `WSEL_7:  width_mask = 32'h0000_007f;
                default:  width_mask = 32'hffff_ffff;
            endcase
        end
    endfunction

    // one byte of the division per cycle
    crc_fold_step u_fold (
        .crc_in    (checksum_value),
        .data_in   (shift_in[31:24]),
        .coeff     (generator_coeff),
        .width_sel (generator_width_sel),
        .crc_out   (step_out)
    );

    // pick the written lane from the strobes
    always @* begin
        lane_value = 32'h0000_0000;
        lane_size  = `SIZE_WORD;
        lane_ok    = 1'b1;
        case (pstrb)
            4'h1: begin
                lane_value = {24'h00_0000, pwdata[7:0]};
                lane_size  = `SIZE_BYTE;
            end
            4'h2: begin
                lane_value = {24'h00_0000, pwdata[15:8]};
                lane_size  = `SIZE_BYTE;
            end
            4'h4: begin
                lane_value = {24'h00_0000, pwdata[23:16]};
                lane_size  = `SIZE_BYTE;
            end
            4'h8: begin
                lane_value = {24'h00_0000, pwdata[31:24]};
                lane_size  = `SIZE_BYTE;
            end
            4'h3: begin
                lane_value = {16'h0000, pwdata[15:0]};
                lane_size  = `SIZE_HALF;
            end
            4'hc: begin
                lane_value = {16'h0000, pwdata[31:16]};
                lane_size  = `SIZE_HALF;
            end
            4'hf: begin
                lane_value = pwdata;
            end
            default: begin
                // odd strobe patterns are refused
                lane_ok = 1'b0;
            end
        endcase
    end

    // reverse input; groups never exceed the input size
    always @* begin
        case (input_bit_flip_sel)
            `IN_FLIP_BYTE: begin
                flipped_in = flip_bytes(lane_value);
            end
            `IN_FLIP_HALF: begin
                if (lane_size == `SIZE_BYTE) begin
                    flipped_in = flip_bytes(lane_value);
                end else begin
                    flipped_in = flip_halves(lane_value);
                end
            end
            `IN_FLIP_WORD: begin
                if (lane_size == `SIZE_BYTE) begin
                    flipped_in = flip_bytes(lane_value);
                end else if (lane_size == `SIZE_HALF) begin
                    flipped_in = flip_halves(lane_value);
                end else begin
                    flipped_in = flip_word(lane_value);
                end
            end
            default: begin
                flipped_in = lane_value;
            end
        endcase
    end

    // left align input so the engine takes it msb first
    always @* begin
        case (lane_size)
            `SIZE_BYTE: begin
                next_feed  = 3'h1;
                next_shift = {flipped_in[7:0], 24'h00_0000};
            end
            `SIZE_HALF: begin
                next_feed  = 3'h2;
                next_shift = {flipped_in[15:0], 16'h0000};
            end
            default: begin
                next_feed  = 3'h4;
                next_shift = flipped_in;
            end
        endcase
    end

    // result as presented on read
    always @* begin
        result_view = (checksum_value & width_mask(generator_width_sel))
                      ^ `FINAL_XOR;
        if (output_bit_flip) begin
            result_view = flip_word(result_view);
        end
    end

    // address decode, read mux and refusal
    always @* begin
        next_err   = 1'b0;
        next_rdata = 32'h0000_0000;
        case (paddr)
            `OFS_CHECKSUM: begin
                next_rdata = result_view;
                next_err   = pwrite & ~lane_ok;
            end
            `OFS_SCRATCH: begin
                next_rdata = {24'h00_0000, scratch_byte};
                next_err   = pwrite & ~wr_word;
            end
            `OFS_CONTROL: begin
                // restart bit always reads zero
                next_rdata = {24'h00_0000, output_bit_flip,
                              input_bit_flip_sel, generator_width_sel,
                              3'h0};
                next_err   = pwrite & ~wr_word;
            end
            `OFS_SEED: begin
                next_rdata = seed_value;
                next_err   = pwrite & ~wr_word;
            end
            `OFS_COEFF: begin
                next_rdata = generator_coeff;
                next_err   = pwrite & ~wr_word;
            end
            default: begin
                // unmapped address
                next_err = 1'b1;
            end
        endcase
    end

    // registers, bus answer and calculation engine
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            checksum_value      <= `RST_CHECKSUM;
            scratch_byte        <= `RST_SCRATCH;
            output_bit_flip     <= 1'b0;
            input_bit_flip_sel  <= `IN_FLIP_NONE;
            generator_width_sel <= `WSEL_32;
            seed_value          <= `RST_SEED;
            generator_coeff     <= `RST_COEFF;
            busy                <= 1'b0;
            calc_cnt            <= 3'h0;
            feed_bytes          <= 3'h0;
            shift_in            <= 32'h0000_0000;
            prdata              <= 32'h0000_0000;
            pready              <= 1'b0;
            pslverr             <= 1'b0;
        end else begin
            // answer lasts one cycle, read data shows only with it
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
            if (busy) begin
                if (calc_cnt < feed_bytes) begin
                    checksum_value <= step_out;
                end
                shift_in <= {shift_in[23:0], 8'h00};
                calc_cnt <= calc_cnt + 3'h1;
                if (calc_cnt == `CALC_CYCLES - 3'h1) begin
                    busy <= 1'b0;
                end
            end
            // accesses wait while a calculation runs
            if (access && !busy) begin
                pready  <= 1'b1;
                pslverr <= next_err;
                prdata  <= pwrite ? 32'h0000_0000 : next_rdata;
                if (pwrite && !next_err) begin
                    case (paddr)
                        `OFS_CHECKSUM: begin
                            busy       <= 1'b1;
                            calc_cnt   <= 3'h0;
                            feed_bytes <= next_feed;
                            shift_in   <= next_shift;
                        end
                        `OFS_SCRATCH: begin
                            scratch_byte <= pwdata[7:0];
                        end
                        `OFS_CONTROL: begin
                            output_bit_flip     <= pwdata[`CTL_OUT_BIT];
                            input_bit_flip_sel  <=
                                pwdata[`CTL_IN_MSB:`CTL_IN_LSB];
                            generator_width_sel <=
                                pwdata[`CTL_WIDTH_MSB:`CTL_WIDTH_LSB];
                            if (pwdata[`CTL_RESTART_BIT]) begin
                                checksum_value <= seed_value;
                            end
                        end
                        `OFS_SEED: begin
                            seed_value <= pwdata;
                        end
                        `OFS_COEFF: begin
                            generator_coeff <= pwdata;
                        end
                        default: begin
                            // refused above
                        end
                    endcase
                end
            end
        end
    end

endmodule // crc32_calc_unit

`default_nettype wire

//--- rtl/crc32_calc_unit_defs.vh
`ifndef CRC32_CALC_UNIT_DEFS_VH
`define CRC32_CALC_UNIT_DEFS_VH

// register byte offsets
`define OFS_CHECKSUM      8'h00
`define OFS_SCRATCH       8'h04
`define OFS_CONTROL       8'h08
`define OFS_SEED          8'h10
`define OFS_COEFF         8'h14

// reset values
`define RST_CHECKSUM      32'hffff_ffff
`define RST_SCRATCH       8'h00
`define RST_SEED          32'hffff_ffff
`define RST_COEFF         32'h04c1_1db7

// control register field positions
`define CTL_RESTART_BIT   0
`define CTL_WIDTH_LSB     3
`define CTL_WIDTH_MSB     4
`define CTL_IN_LSB        5
`define CTL_IN_MSB        6
`define CTL_OUT_BIT       7

// generator width select codes
`define WSEL_32           2'h0
`define WSEL_16           2'h1
`define WSEL_8            2'h2
`define WSEL_7            2'h3

// input bit flip select codes
`define IN_FLIP_NONE      2'h0
`define IN_FLIP_BYTE      2'h1
`define IN_FLIP_HALF      2'h2
`define IN_FLIP_WORD      2'h3

// input size codes
`define SIZE_BYTE         2'h0
`define SIZE_HALF         2'h1
`define SIZE_WORD         2'h2

// final xor value and cycles per calculation
`define FINAL_XOR         32'h0000_0000
`define CALC_CYCLES       3'h4

`endif

//--- rtl/crc_fold_step.v
`timescale 1ns/1ps
`default_nettype none
`include "crc32_calc_unit_defs.vh"

// folds one byte, msb first, into the running remainder
module crc_fold_step (
    input  wire [31:0] crc_in,
    input  wire [7:0]  data_in,
    input  wire [31:0] coeff,
    input  wire [1:0]  width_sel,
    output reg  [31:0] crc_out
);

    reg [31:0] c;     // working remainder
    reg [31:0] m;     // mask of live remainder bits
    reg [4:0]  top;   // index of the remainder's top bit
    reg        fb;    // feedback bit
    integer    i;

    // live bits of the remainder for a generator width
    function [31:0] width_mask;
        input [1:0] sel;
        begin
            case (sel)
                `WSEL_16: width_mask = 32'h0000_ffff;
                `WSEL_8:  width_mask = 32'h0000_00ff;
                `WSEL_7:  width_mask = 32'h0000_007f;
                default:  width_mask = 32'hffff_ffff;
            endcase
        end
    endfunction

    // position of the top bit for a generator width
    function [4:0] top_bit;
        input [1:0] sel;
        begin
            case (sel)
                `WSEL_16: top_bit = 5'd15;
                `WSEL_8:  top_bit = 5'd7;
                `WSEL_7:  top_bit = 5'd6;
                default:  top_bit = 5'd31;
            endcase
        end
    endfunction

    // eight serial modulo 2 division steps, low coeff bits only
    always @* begin
        m   = width_mask(width_sel);
        top = top_bit(width_sel);
        c   = crc_in & m;
        fb  = 1'b0;
        for (i = 7; i >= 0; i = i - 1) begin
            fb = c[top] ^ data_in[i];
            c  = {c[30:0], 1'b0} & m;
            if (fb) begin
                c = c ^ (coeff & m);
            end
        end
        crc_out = c;
    end

endmodule // crc_fold_step

`default_nettype wire

//--- sim/crc32_calc_unit_chk.sv
`timescale 1ns/1ps
`default_nettype none
// watches the apb side of the crc unit
module crc32_calc_unit_chk (
    input wire        pclk,
    input wire        presetn,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [7:0]  paddr,
    input wire [31:0] pwdata,
    input wire [3:0]  pstrb,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        pslverr
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // address hits one of the five registers
    wire mapped = paddr inside {8'h00, 8'h04, 8'h08, 8'h10, 8'h14};
    // data write answered without error
    wire dwr = pready && !pslverr && pwrite && (paddr == 8'h00);

    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    ready_bound_a: assert property (
        $rose(penable) && psel |-> ##[1:6] pready)
        else $error("no answer to access");
    calc_four_a: assert property (dwr |=> !pready [*3])
        else $error("answer during calculation");
    unmapped_err_a: assert property (
        pready && !mapped |-> pslverr)
        else $error("unmapped access accepted");
    narrow_ctl_a: assert property (
        pready && pwrite && paddr != 8'h00 && pstrb != 4'hf |-> pslverr)
        else $error("narrow write accepted");
    read_ok_a: assert property (
        pready && !pwrite && mapped |-> !pslverr)
        else $error("read refused");
    restart_zero_a: assert property (
        pready && !pwrite && paddr == 8'h08 |-> prdata[0] == 1'b0)
        else $error("restart bit reads one");
    scratch_byte_a: assert property (
        pready && !pwrite && paddr == 8'h04 |-> prdata[31:8] == 24'h0)
        else $error("scratch upper bits set");
    idle_data_a: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside answer");
endmodule // crc32_calc_unit_chk

bind crc32_calc_unit crc32_calc_unit_chk u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));
`default_nettype wire

//--- sim/test_crc32_calc_unit.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin \
    num_errors++; $display("mismatch at %0t: %h vs %h", $time, g, e); \
    end end
module test_crc32_calc_unit;
    reg         pclk    = 0;
    reg         presetn = 0;
    reg         psel    = 0;
    reg         penable = 0;
    reg         pwrite  = 0;
    reg [7:0]   paddr   = 8'h00;
    reg [31:0]  pwdata  = 32'h0000_0000;
    reg [3:0]   pstrb   = 4'h0;
    wire [31:0] prdata;
    wire        pready;
    wire        pslverr;
    reg [31:0]  rdat;                     // last read data
    reg         rerr;                     // last error flag
    int         num_errors = 0;
    int         tests_run  = 0;
    reg [31:0]  m_crc   = 32'hffff_ffff;  // model remainder
    reg [31:0]  m_seed  = 32'hffff_ffff;  // model seed
    reg [31:0]  m_coeff = 32'h04c1_1db7;  // model coefficient
    reg [31:0]  m_ctl   = 32'h0000_0000;  // model control
    integer     i;

    // free running clock, 4 ns period
    always #2 pclk = ~pclk;

    crc32_calc_unit u_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr));

    // one apb transfer, held until pready is sampled
    task xfer(input reg w, input reg [7:0] a, input reg [31:0] d,
              input reg [3:0] s);
        integer n;
        begin
            @(posedge pclk);
            psel <= 1; penable <= 0; pwrite <= w; paddr <= a;
            pwdata <= d; pstrb <= w ? s : 4'h0;
            @(posedge pclk);
            penable <= 1;
            n = 0;
            do begin @(posedge pclk); n++; end
            while (pready !== 1'b1 && n < 20);
            rdat = prdata;
            rerr = pslverr;
            psel <= 0;
            penable <= 0;
            if (n >= 20) begin
                num_errors++;
                $display("mismatch at %0t: no answer", $time);
            end
        end
    endtask

    // read and compare, data only when accepted
    task rdx(input reg [7:0] a, input reg [31:0] e, input reg ee);
        begin
            xfer(0, a, 32'h0, 4'h0);
            `CHK(rerr, ee)
            if (!ee) `CHK(rdat, e)
        end
    endtask

    // write and compare the error flag
    task wrx(input reg [7:0] a, input reg [31:0] d, input reg [3:0] s,
             input reg ee);
        begin
            xfer(1, a, d, s);
            `CHK(rerr, ee)
        end
    endtask

    // mirror the low n bits in groups of g
    function [31:0] mir(input [31:0] v, input integer n, input integer g);
        integer k, b;
        begin
            mir = v;
            for (k = 0; k < n; k++) begin
                b = k - k % g;
                mir[b + g - 1 - (k - b)] = v[k];
            end
        end
    endfunction

    // remainder mask for the selected width
    function [31:0] wmask();
        case (m_ctl[4:3])
            2'h0: wmask = 32'hffff_ffff;
            2'h1: wmask = 32'h0000_ffff;
            2'h2: wmask = 32'h0000_00ff;
            default: wmask = 32'h0000_007f;
        endcase
    endfunction

    // msb first division of n input bits
    function [31:0] step(input [31:0] c, input [31:0] d, input integer n);
        integer k, w;
        reg t;
        begin
            w = $clog2(wmask() + 33'h1);
            c = c & wmask();
            for (k = n - 1; k >= 0; k--) begin
                t = c[w - 1] ^ d[k];
                c = (c << 1) & wmask();
                if (t) c = c ^ (m_coeff & wmask());
            end
            step = c;
        end
    endfunction

    // expected data register read
    function [31:0] expv();
        expv = m_ctl[7] ? mir(m_crc & wmask(), 32, 32) : m_crc & wmask();
    endfunction

    // feed one input of n bytes taken from byte lane ln upward
    task feed_at(input reg [31:0] d, input integer n, input integer ln);
        integer g;
        reg [31:0] v;
        reg [3:0]  s;
        begin
            v = d >> (8 * ln);
            v = (n == 4) ? v : v & ((32'h1 << (8 * n)) - 32'h1);
            g = (m_ctl[6:5] == 2'h1) ? 8 : (m_ctl[6:5] == 2'h2) ? 16 : 32;
            if (g > 8 * n) g = 8 * n;
            if (m_ctl[6:5] != 2'h0) v = mir(v, 8 * n, g);
            m_crc = step(m_crc, v, 8 * n);
            s = (n == 1) ? 4'h1 : (n == 2) ? 4'h3 : 4'hf;
            s = s << ln;
            wrx(8'h00, d, s, 0);
        end
    endtask

    // feed one input of n bytes in the low lanes
    task feed(input reg [31:0] d, input integer n);
        begin
            feed_at(d, n, 0);
        end
    endtask

    // control write, restart reloads the seed
    task ctl(input reg [31:0] d);
        begin
            m_ctl = d & 32'h0000_00f8;
            if (d[0]) m_crc = m_seed;
            wrx(8'h08, d, 4'hf, 0);
        end
    endtask

    // closing report and verdict
    task wrap_up();
        begin
            $display("checks %0d, mismatches %0d", tests_run, num_errors);
            if (num_errors == 0 && tests_run > 0)
                $display("ALL TESTS PASSED");
            else
                $display("TESTS FAILED");
            $finish;
        end
    endtask

    // hang guard
    initial begin
        #40000;
        num_errors++;
        $display("mismatch at %0t: watchdog", $time);
        wrap_up();
    end

    // main sequence
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1;
        rdx(8'h00, 32'hffff_ffff, 0);
        rdx(8'h04, 32'h0000_0000, 0);
        rdx(8'h08, 32'h0000_0000, 0);
        rdx(8'h10, 32'hffff_ffff, 0);
        rdx(8'h14, 32'h04c1_1db7, 0);
        rdx(8'h0c, 32'h0, 1);
        rdx(8'h02, 32'h0, 1);
        wrx(8'h08, 32'h0000_0080, 4'h3, 1);
        rdx(8'h08, 32'h0000_0000, 0);
        feed(32'h1234_5678, 4);
        feed(32'hdead_beef, 4);
        rdx(8'h00, expv(), 0);
        ctl(32'h0000_0000);
        rdx(8'h00, expv(), 0);
        m_seed = 32'h5a5a_0f0f;
        wrx(8'h10, m_seed, 4'hf, 0);
        ctl(32'h0000_0001);
        rdx(8'h00, expv(), 0);
        rdx(8'h08, 32'h0000_0000, 0);
        // every input flip code with both output settings
        for (i = 0; i < 8; i++) begin
            ctl({24'h0, i[2], i[1:0], 5'h01});
            rdx(8'h08, m_ctl, 0);
            feed(32'h1234_5678, 4);
            feed(32'h0000_00c3, 1);
            feed(32'h0000_9a7e, 2);
            rdx(8'h00, expv(), 0);
        end
        // narrow generator widths with a new coefficient
        m_coeff = 32'h1234_8b37;
        wrx(8'h14, m_coeff, 4'hf, 0);
        rdx(8'h14, m_coeff, 0);
        for (i = 1; i < 4; i++) begin
            ctl({27'h0, i[1:0], 3'h1});
            feed(32'hcafe_f00d, 4);
            feed(32'h0000_005b, 1);
            rdx(8'h00, expv(), 0);
        end
        // upper byte lanes, then a refused strobe pattern
        ctl(32'h0000_0021);
        feed_at(32'hb400_0000, 1, 3);
        feed_at(32'h00e1_0000, 1, 2);
        feed_at(32'h0000_6900, 1, 1);
        feed_at(32'h3c5a_0000, 2, 2);
        wrx(8'h00, 32'hffff_ffff, 4'h5, 1);
        rdx(8'h00, expv(), 0);
        // scratch byte across a restart
        wrx(8'h04, 32'hffff_ffa5, 4'hf, 0);
        wrx(8'h04, 32'h0000_0000, 4'h1, 1);
        ctl(32'h0000_0001);
        rdx(8'h04, 32'h0000_00a5, 0);
        rdx(8'h00, expv(), 0);
        // a reset in mid run restores every register
        @(posedge pclk);
        presetn <= 0;
        repeat (2) @(posedge pclk);
        presetn <= 1;
        rdx(8'h00, 32'hffff_ffff, 0);
        rdx(8'h04, 32'h0000_0000, 0);
        rdx(8'h08, 32'h0000_0000, 0);
        rdx(8'h10, 32'hffff_ffff, 0);
        rdx(8'h14, 32'h04c1_1db7, 0);
        wrap_up();
    end
endmodule // test_crc32_calc_unit
`default_nettype wire
